// *** core/bei_defs.svh ***
// offsets, field positions, reset values and counts for the error insert and monitor block
`ifndef BEI_DEFS_SVH
`define BEI_DEFS_SVH
// register word indices, byte address is four times the index
`define BEI_IDX_INS_CTRL 8'h08
`define BEI_IDX_LIVE 8'h0c
`define BEI_IDX_LATCHED 8'h0e
`define BEI_IDX_IRQ_EN 8'h10
`define BEI_IDX_ERR0 8'h14
`define BEI_IDX_ERR1 8'h15
`define BEI_IDX_ERR2 8'h16
`define BEI_IDX_BIT0 8'h18
`define BEI_IDX_BIT1 8'h19
`define BEI_IDX_BIT2 8'h1a
`define BEI_IDX_BIT3 8'h1b
`define BEI_IDX_TEST_CTRL 8'h20
// insertion control fields
`define BEI_RATE_HI 5
`define BEI_RATE_LO 3
`define BEI_SINGLE_EN 2
`define BEI_SINGLE_REQ 1
`define BEI_SRC_SEL 0
// test control fields
`define BEI_UPD_SRC 7
`define BEI_LOCAL_UPD 6
`define BEI_RESYNC_DIS 2
// status bit positions, shared by live, latched and enable registers
`define BEI_ST_UPDATE 3
`define BEI_ST_BITERR 2
`define BEI_ST_COUNT 1
`define BEI_ST_SYNC 0
// reset values
`define BEI_RST_BYTE 8'h00
// sync monitor counts
`define BEI_WINDOW_BITS 64
`define BEI_LOSS_ERRORS 6
`define BEI_RELOCK_BITS 32
`endif

// *** core/bei_pkg.sv ***
// types for the error insert and monitor block
package bei_pkg;
  typedef enum logic {
    bei_hunt,
    bei_locked
  } bei_sync_t;
  typedef logic [7:0] bei_byte_t;
endpackage

// *** core/bei_top.sv ***
// bit error insertion, sync monitor, counters and apb registers for one channel
//
// Contract
// - invert one tx bit per 10**n bits, n from rate field, zero disables
// - rate insertion starts when control is written with nonzero rate
// - rewritten rate takes effect only after next error at old rate
// - single error insertion works only while single enable is set
// - each rising request edge inverts one bit; software lowers it between
// - several request toggles between opportunities give only one error
// - source select picks register request or external insert input
// - update done rises after update, drops when selected trigger is low
// - live count bit is one while error count is nonzero
// - live sync bit is one while the checker is out of sync
// - latched update flag sets on rising update done
// - latched bit error flag sets on any bit error detected while in sync
// - latched count flag sets on rising live count bit
// - latched sync flag sets on any change of live sync bit
// - reading latched status clears its flags
// - each latched flag has its own interrupt enable
// - 24-bit error counter saturating at all ones
// - error counter holds while out of sync
// - 32-bit received bit counter saturating at all ones
// - bit counter holds while out of sync
// - update copies counts to readable registers and resets counters
// - update source select picks local bit edge or external update
// - six mismatches in a 64-bit window drop sync unless resync disabled
//
// Local design decision: register access over APB.
`include "bei_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module bei_top #(
  parameter int ERR_W = 24,
  parameter int BIT_W = 32,
  parameter int RELOCK_BITS = `BEI_RELOCK_BITS
) (
  input wire logic clk, // 200 MHz
  input wire logic srst, // sync reset, high
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [9:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped
  input wire logic tx_bit_valid, // tx bit strobe
  input wire logic tx_bit_in, // tx bit from generator
  output logic tx_bit_out_valid, // tx bit strobe out
  output logic tx_bit_out, // tx bit after insertion
  input wire logic rx_bit_valid, // rx bit strobe
  input wire logic rx_bit_mismatch, // rx bit differs from reference
  input wire logic external_insert_input, // async manual insert pin
  input wire logic external_update_input, // async update pin
  output logic sync_lost, // checker out of sync
  output logic irq // interrupt request, high
);
  logic ext_ins_m, ext_ins_s, ext_upd_m, ext_upd_s;
  logic [7:0] ins_ctrl, test_ctrl, irq_en, latched;
  logic [23:0] period, rate_cnt;
  logic [2:0] active_rate, pend_rate;
  logic pend_valid, rate_hit;
  logic ins_trig, ins_trig_q, single_pend;
  logic upd_trig, upd_trig_q, upd_done;
  logic [ERR_W-1:0] err_cnt, err_snap;
  logic [BIT_W-1:0] bit_cnt, bit_snap;
  logic [5:0] win_pos;
  logic [2:0] win_err;
  logic [5:0] relock_cnt;
  bei_pkg::bei_sync_t sync_state;
  logic sync_lost_q, count_nz_q, done_live_q;
  logic acc, wr_en, rd_en, setup, hit;
  logic [7:0] idx, rd_byte, rd_mask;
  logic [3:0] live, set_evt;
  logic err_inc, bit_inc, upd_go, bit_err_evt;

  // pins from outside the clock domain pass two flops first
  always_ff @(posedge clk)
  begin
    ext_ins_m <= external_insert_input;
    ext_ins_s <= ext_ins_m;
    ext_upd_m <= external_update_input;
    ext_upd_s <= ext_upd_m;
  end

  // apb decode, writes and reads land at the access edge
  assign idx = paddr[9:2];
  assign setup = psel & ~penable;
  assign acc = psel & penable & pready;
  assign wr_en = acc & pwrite & ~pslverr;
  assign rd_en = acc & ~pwrite;
  assign hit = idx == `BEI_IDX_INS_CTRL || idx == `BEI_IDX_LIVE
    || idx == `BEI_IDX_LATCHED || idx == `BEI_IDX_IRQ_EN
    || idx == `BEI_IDX_ERR0 || idx == `BEI_IDX_ERR1 || idx == `BEI_IDX_ERR2
    || idx == `BEI_IDX_BIT0 || idx == `BEI_IDX_BIT1 || idx == `BEI_IDX_BIT2
    || idx == `BEI_IDX_BIT3 || idx == `BEI_IDX_TEST_CTRL;

  // live status view; update done is masked by the trigger level
  assign live = {done_live_q & upd_trig, 1'b0, count_nz_q, sync_lost_q};

  // read mux
  always_comb
  begin
    rd_byte = `BEI_RST_BYTE;
    case (idx)
      `BEI_IDX_INS_CTRL: rd_byte = ins_ctrl;
      `BEI_IDX_LIVE: rd_byte = {4'h0, live};
      `BEI_IDX_LATCHED: rd_byte = latched;
      `BEI_IDX_IRQ_EN: rd_byte = irq_en;
      `BEI_IDX_ERR0: rd_byte = err_snap[7:0];
      `BEI_IDX_ERR1: rd_byte = err_snap[15:8];
      `BEI_IDX_ERR2: rd_byte = err_snap[23:16];
      `BEI_IDX_BIT0: rd_byte = bit_snap[7:0];
      `BEI_IDX_BIT1: rd_byte = bit_snap[15:8];
      `BEI_IDX_BIT2: rd_byte = bit_snap[23:16];
      `BEI_IDX_BIT3: rd_byte = bit_snap[31:24];
      `BEI_IDX_TEST_CTRL: rd_byte = test_ctrl;
      default: rd_byte = `BEI_RST_BYTE;
    endcase
  end

  // no wait state: answer is registered during setup
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= setup;
      pslverr <= setup & ~hit;
      if (setup & ~pwrite)
        prdata <= {24'h00_0000, rd_byte};
    end
  end

  // software control registers
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ins_ctrl <= `BEI_RST_BYTE;
      test_ctrl <= `BEI_RST_BYTE;
      irq_en <= `BEI_RST_BYTE;
    end
    else if (wr_en)
    begin
      if (idx == `BEI_IDX_INS_CTRL)
        ins_ctrl <= {2'b00, pwdata[5:0]};
      if (idx == `BEI_IDX_TEST_CTRL)
        test_ctrl <= pwdata[7:0];
      if (idx == `BEI_IDX_IRQ_EN)
        irq_en <= {4'h0, pwdata[3:0]};
    end
  end

  // decade period lookup for the rate exponent
  always_comb
  begin
    case (active_rate)
      3'd1: period = 24'd10;
      3'd2: period = 24'd100;
      3'd3: period = 24'd1000;
      3'd4: period = 24'd10000;
      3'd5: period = 24'd100000;
      3'd6: period = 24'd1000000;
      3'd7: period = 24'd10000000;
      default: period = 24'd0;
    endcase
  end
  assign rate_hit = tx_bit_valid && active_rate != 3'd0 && rate_cnt == period - 24'd1;

  // rate engine; a new rate waits for the next error of the running one
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      active_rate <= 3'd0;
      pend_rate <= 3'd0;
      pend_valid <= 1'b0;
      rate_cnt <= 24'h00_0000;
    end
    else if (wr_en && idx == `BEI_IDX_INS_CTRL && active_rate == 3'd0)
    begin
      active_rate <= pwdata[`BEI_RATE_HI:`BEI_RATE_LO];
      rate_cnt <= 24'h00_0000;
      pend_valid <= 1'b0;
    end
    else
    begin
      if (rate_hit)
      begin
        rate_cnt <= 24'h00_0000;
        if (pend_valid)
        begin
          active_rate <= pend_rate;
          pend_valid <= 1'b0;
        end
      end
      else if (tx_bit_valid && active_rate != 3'd0)
        rate_cnt <= rate_cnt + 24'd1;
      // a write landing with an error stays pending, never lost
      if (wr_en && idx == `BEI_IDX_INS_CTRL)
      begin
        pend_rate <= pwdata[`BEI_RATE_HI:`BEI_RATE_LO];
        pend_valid <= 1'b1;
      end
    end
  end

  // manual trigger source; edge taken on the selected level, so a
  // source switch with a high trigger may give one error
  assign ins_trig = ins_ctrl[`BEI_SRC_SEL] ? ext_ins_s : ins_ctrl[`BEI_SINGLE_REQ];

  // single error request holds one pending error until a tx bit
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ins_trig_q <= 1'b0;
      single_pend <= 1'b0;
    end
    else
    begin
      ins_trig_q <= ins_trig;
      // a request edge beside a tx bit arms the following bit
      if (ins_trig & ~ins_trig_q & ins_ctrl[`BEI_SINGLE_EN])
        single_pend <= 1'b1;
      else if (tx_bit_valid)
        single_pend <= 1'b0;
    end
  end

  // transmit path, one cycle of latency
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      tx_bit_out_valid <= 1'b0;
      tx_bit_out <= 1'b0;
    end
    else
    begin
      tx_bit_out_valid <= tx_bit_valid;
      if (tx_bit_valid)
        tx_bit_out <= tx_bit_in ^ (rate_hit | single_pend);
    end
  end

  // sync monitor: window of mismatches while locked, run of matches while hunting
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      sync_state <= bei_pkg::bei_hunt;
      win_pos <= 6'd0;
      win_err <= 3'd0;
      relock_cnt <= 6'd0;
    end
    else if (rx_bit_valid)
    begin
      case (sync_state)
        bei_pkg::bei_hunt:
        begin
          win_pos <= 6'd0;
          win_err <= 3'd0;
          if (rx_bit_mismatch)
            relock_cnt <= 6'd0;
          else if (relock_cnt == 6'(RELOCK_BITS - 1))
          begin
            relock_cnt <= 6'd0;
            sync_state <= bei_pkg::bei_locked;
          end
          else
            relock_cnt <= relock_cnt + 6'd1;
        end
        bei_pkg::bei_locked:
        begin
          win_pos <= win_pos + 6'd1; // wraps every 64 bits
          if (win_pos == 6'(`BEI_WINDOW_BITS - 1))
            win_err <= 3'd0;
          else if (rx_bit_mismatch && win_err != 3'd7)
            win_err <= win_err + 3'd1;
          if (rx_bit_mismatch && win_err == 3'(`BEI_LOSS_ERRORS - 1)
              && !test_ctrl[`BEI_RESYNC_DIS])
            sync_state <= bei_pkg::bei_hunt;
        end
        default: sync_state <= bei_pkg::bei_hunt;
      endcase
    end
  end

  // counters run only while locked and saturate at all ones
  assign err_inc = rx_bit_valid && rx_bit_mismatch && sync_state == bei_pkg::bei_locked;
  assign bit_inc = rx_bit_valid && sync_state == bei_pkg::bei_locked;
  assign bit_err_evt = err_inc;

  // update trigger and its rising edge
  assign upd_trig = test_ctrl[`BEI_UPD_SRC] ? ext_upd_s : test_ctrl[`BEI_LOCAL_UPD];
  assign upd_go = upd_trig & ~upd_trig_q;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      err_cnt <= '0;
      bit_cnt <= '0;
      err_snap <= '0;
      bit_snap <= '0;
      upd_trig_q <= 1'b0;
      upd_done <= 1'b0;
    end
    else
    begin
      upd_trig_q <= upd_trig;
      if (upd_go)
      begin
        // counting bit of this cycle starts the fresh count
        err_snap <= err_cnt;
        bit_snap <= bit_cnt;
        err_cnt <= ERR_W'(err_inc);
        bit_cnt <= BIT_W'(bit_inc);
      end
      else
      begin
        if (err_inc && err_cnt != '1)
          err_cnt <= err_cnt + ERR_W'(1);
        if (bit_inc && bit_cnt != '1)
          bit_cnt <= bit_cnt + BIT_W'(1);
      end
      if (!upd_trig)
        upd_done <= 1'b0;
      else if (upd_go)
        upd_done <= 1'b1;
    end
  end

  // live status flops and event detection
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      sync_lost_q <= 1'b1;
      count_nz_q <= 1'b0;
      done_live_q <= 1'b0;
      sync_lost <= 1'b1;
    end
    else
    begin
      sync_lost_q <= sync_state != bei_pkg::bei_locked;
      sync_lost <= sync_state != bei_pkg::bei_locked;
      count_nz_q <= err_cnt != '0;
      done_live_q <= upd_done & upd_trig;
    end
  end

  assign set_evt[`BEI_ST_UPDATE] = upd_done & upd_trig & ~done_live_q;
  assign set_evt[`BEI_ST_BITERR] = bit_err_evt;
  assign set_evt[`BEI_ST_COUNT] = (err_cnt != '0) & ~count_nz_q;
  assign set_evt[`BEI_ST_SYNC] = (sync_state != bei_pkg::bei_locked) ^ sync_lost_q;

  // read clears only bits that were returned; a new event wins
  assign rd_mask = (rd_en && idx == `BEI_IDX_LATCHED) ? prdata[7:0] : 8'h00;

  always_ff @(posedge clk)
  begin
    if (srst)
      latched <= `BEI_RST_BYTE;
    else
      latched <= (latched & ~rd_mask) | {4'h0, set_evt};
  end

  // interrupt request
  always_ff @(posedge clk)
  begin
    if (srst)
      irq <= 1'b0;
    else
      irq <= |(latched & irq_en);
  end
endmodule
`default_nettype wire

// *** testbench/bei_checker.sv ***
// port assertions for the error insert and monitor block
`timescale 1ns/1ps
`default_nettype none
module bei_checker (
  input wire logic clk, // clock
  input wire logic srst, // sync reset
  input wire logic psel, // apb select
  input wire logic penable, // apb access
  input wire logic pwrite, // apb direction
  input wire logic [9:0] paddr, // apb address
  input wire logic [31:0] prdata, // read data
  input wire logic pready, // apb ready
  input wire logic pslverr, // apb error
  input wire logic tx_bit_valid, // tx strobe in
  input wire logic tx_bit_out_valid, // tx strobe out
  input wire logic rx_bit_valid, // rx strobe
  input wire logic rx_bit_mismatch, // rx bit wrong
  input wire logic sync_lost, // out of sync
  input wire logic irq // interrupt
);
  logic bad;
  logic good;
  // rx events as the sync monitor sees them
  assign bad = rx_bit_valid && rx_bit_mismatch;
  assign good = rx_bit_valid && !rx_bit_mismatch;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  // insertion must never add or drop a strobe
  property p_txv;
    1'b1 |=> tx_bit_out_valid == $past(tx_bit_valid);
  endproperty
  a_txv: assert property (p_txv) else $error("tx strobe lost");
  property p_rdy;
    psel && !penable |=> pready;
  endproperty
  a_rdy: assert property (p_rdy) else $error("no ready after setup");
  property p_one;
    pready |=> !pready;
  endproperty
  a_one: assert property (p_one) else $error("ready held too long");
  property p_err;
    pslverr |-> pready && $past(psel && !penable);
  endproperty
  a_err: assert property (p_err) else $error("stray slave error");
  // guard on a stable level, the live copy may trail by a cycle
  property p_live;
    psel && !penable && !pwrite && paddr[9:2] == 8'h0c && $stable(sync_lost) |=> prdata[0] == $past(sync_lost);
  endproperty
  a_live: assert property (p_live) else $error("live sync bit wrong");
  property p_loss;
    $rose(sync_lost) && !$past(srst) |-> $past(bad) || $past(bad, 2) || $past(bad, 3);
  endproperty
  a_loss: assert property (p_loss) else $error("sync lost without error");
  property p_lock;
    $fell(sync_lost) |-> $past(good) || $past(good, 2) || $past(good, 3);
  endproperty
  a_lock: assert property (p_lock) else $error("lock without good bit");
  property p_irq;
    $fell(srst) |-> !irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq set after reset");
  c_loss: cover property ($rose(sync_lost));
  c_irq: cover property (irq);
  c_err: cover property (pslverr);
endmodule
bind bei_top bei_checker u_bei_checker (.clk, .srst, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
  .pslverr, .tx_bit_valid, .tx_bit_out_valid, .rx_bit_valid, .rx_bit_mismatch, .sync_lost, .irq);
`default_nettype wire

// *** testbench/bei_partner.sv ***
// far side stream model: sends a pattern, loops it back and compares
`timescale 1ns/1ps
`default_nettype none
module bei_partner (
  input wire logic clk, // clock
  input wire logic run, // stream on
  input wire logic slow, // one bit every other cycle
  input wire logic tx_bit_out_valid, // bit back from block
  input wire logic tx_bit_out, // maybe inverted bit
  output logic tx_bit_valid, // strobe to block
  output logic tx_bit_in, // pattern bit
  output logic rx_bit_valid, // rx strobe to block
  output logic rx_bit_mismatch // looped bit differs
);
  logic [3:0] cnt = 4'h0;
  logic sent = 1'h0;
  // pattern keeps moving so a stuck output cannot pass
  assign tx_bit_valid = run && (!slow || cnt[0]);
  assign tx_bit_in = cnt[1] ^ cnt[3];
  always_ff @(posedge clk)
  begin
    cnt <= cnt + 4'h1;
    if (tx_bit_valid)
    begin
      sent <= tx_bit_in;
    end
  end
  // between bits the mismatch line carries noise, not the last value
  assign rx_bit_valid = tx_bit_out_valid;
  assign rx_bit_mismatch = tx_bit_out_valid ? tx_bit_out ^ sent : cnt[0];
endmodule
`default_nettype wire

// *** testbench/tb.sv ***
// self-checking bench for the error insert and monitor block
`include "bei_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module tb;
  typedef struct {logic [7:0] idx; logic [7:0] val; logic err;} bei_row_t;
  logic clk = 1'h0, srst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, serr;
  logic [9:0] paddr = 10'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, got;
  logic pready, pslverr, tx_bit_valid, tx_bit_in, tx_bit_out_valid, tx_bit_out;
  logic rx_bit_valid, rx_bit_mismatch, sync_lost, irq, run = 1'h0, slow = 1'h0;
  logic external_insert_input = 1'h0, external_update_input = 1'h0;
  int failures = 0, total_checks = 0, errs = 0, cyc = 0;
  bei_row_t rows [13] = '{'{8'h08, 8'h00, 1'h0}, '{8'h0c, 8'h01, 1'h0}, '{8'h0e, 8'h00, 1'h0},
    '{8'h10, 8'h00, 1'h0}, '{8'h14, 8'h00, 1'h0}, '{8'h15, 8'h00, 1'h0}, '{8'h16, 8'h00, 1'h0},
    '{8'h18, 8'h00, 1'h0}, '{8'h19, 8'h00, 1'h0}, '{8'h1a, 8'h00, 1'h0}, '{8'h1b, 8'h00, 1'h0},
    '{8'h20, 8'h00, 1'h0}, '{8'hff, 8'h00, 1'h1}};
  bei_top #(.RELOCK_BITS(4)) u_bei_top (.clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .tx_bit_valid, .tx_bit_in, .tx_bit_out_valid, .tx_bit_out, .rx_bit_valid,
    .rx_bit_mismatch, .external_insert_input, .external_update_input, .sync_lost, .irq);
  bei_partner u_bei_partner (.clk, .run, .slow, .tx_bit_out_valid, .tx_bit_out, .tx_bit_valid, .tx_bit_in,
    .rx_bit_valid, .rx_bit_mismatch);
  initial
  begin
    forever #2.5 clk = ~clk;
  end
  // error tally on the loop, and a ceiling far above the planned run
  always @(posedge clk)
  begin
    cyc++;
    if (rx_bit_valid && rx_bit_mismatch === 1'h1)
      errs++;
    if (cyc == 10000)
    begin
      failures++;
      final_report;
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    total_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value %s exp %h got %h", what, exp, seen);
    end
  endtask
  // one apb transfer, held until ready is sampled
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= {idx, 2'h0};
    pwdata <= {24'h00_0000, d};
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1); // only the bench ceiling ends a hung wait
    got = prdata;
    serr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic rd(input string what, input logic [7:0] idx, input logic [7:0] exp);
    apb(1'h0, idx, 8'h00);
    chk(what, {24'h00_0000, exp}, got);
  endtask
  // stream exactly n bits, then let the loop drain
  task automatic go(input int n);
    run <= 1'h1;
    while (n > 0)
    begin
      @(posedge clk);
      if (tx_bit_valid)
        n--;
    end
    run <= 1'h0;
    repeat (4) @(posedge clk);
  endtask
  task automatic final_report;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (4) @(posedge clk);
    srst <= 1'h0;
    foreach (rows[i])
    begin
      rd("reg", rows[i].idx, rows[i].val);
      chk("slverr", rows[i].err, serr);
    end
    go(8);
    rd("live", `BEI_IDX_LIVE, 8'h00);
    chk("irq", 0, irq);
    rd("latched", `BEI_IDX_LATCHED, 8'h01);
    rd("latched", `BEI_IDX_LATCHED, 8'h00);
    apb(1'h1, `BEI_IDX_TEST_CTRL, 8'h44);
    @(posedge clk); // live update bit trails the write by two edges
    rd("live", `BEI_IDX_LIVE, 8'h08);
    apb(1'h1, `BEI_IDX_TEST_CTRL, 8'h04);
    rd("live", `BEI_IDX_LIVE, 8'h00);
    rd("latched", `BEI_IDX_LATCHED, 8'h08);
    rd("bitcnt", `BEI_IDX_BIT0, 8'h04);
    apb(1'h1, `BEI_IDX_IRQ_EN, 8'h04);
    apb(1'h1, `BEI_IDX_INS_CTRL, 8'h08);
    errs = 0;
    go(100);
    chk("errs", 10, errs);
    chk("sync", 0, sync_lost);
    chk("irq", 1, irq);
    rd("live", `BEI_IDX_LIVE, 8'h02);
    rd("latched", `BEI_IDX_LATCHED, 8'h06);
    repeat (2) @(posedge clk);
    chk("irq", 0, irq);
    apb(1'h1, `BEI_IDX_TEST_CTRL, 8'h44);
    apb(1'h1, `BEI_IDX_TEST_CTRL, 8'h04);
    rd("errcnt", `BEI_IDX_ERR0, 8'h0a);
    rd("bitcnt", `BEI_IDX_BIT0, 8'h64);
    rd("bitcnt1", `BEI_IDX_BIT1, 8'h00);
    rd("live", `BEI_IDX_LIVE, 8'h00);
    // old rate finishes its period before the new one applies
    apb(1'h1, `BEI_IDX_INS_CTRL, 8'h10);
    go(110);
    chk("errs", 12, errs);
    apb(1'h1, `BEI_IDX_INS_CTRL, 8'h00);
    go(300);
    chk("errs", 13, errs);
    slow <= 1'h1;
    apb(1'h1, `BEI_IDX_INS_CTRL, 8'h02);
    go(10);
    chk("errs", 13, errs);
    apb(1'h1, `BEI_IDX_INS_CTRL, 8'h04);
    apb(1'h1, `BEI_IDX_INS_CTRL, 8'h06);
    apb(1'h1, `BEI_IDX_INS_CTRL, 8'h04);
    apb(1'h1, `BEI_IDX_INS_CTRL, 8'h06);
    go(10);
    chk("errs", 14, errs);
    apb(1'h1, `BEI_IDX_INS_CTRL, 8'h04);
    apb(1'h1, `BEI_IDX_INS_CTRL, 8'h05);
    external_insert_input <= 1'h1;
    repeat (5) @(posedge clk);
    external_insert_input <= 1'h0;
    go(10);
    chk("errs", 15, errs);
    slow <= 1'h0;
    rd("latched", `BEI_IDX_LATCHED, 8'h0e);
    apb(1'h1, `BEI_IDX_TEST_CTRL, 8'h00);
    apb(1'h1, `BEI_IDX_INS_CTRL, 8'h08);
    go(140);
    rd("latched", `BEI_IDX_LATCHED, 8'h05);
    srst <= 1'h1;
    repeat (2) @(posedge clk);
    srst <= 1'h0;
    rd("live", `BEI_IDX_LIVE, 8'h01);
    final_report;
  end
endmodule
`default_nettype wire
